// file: inc/ebaidl_pkg.sv
package ebaidl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map and fields
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_GAP      = 8'h08;
  localparam int          CTL_BLOCK    = 0;
  localparam int          CTL_DPR      = 1;
  localparam int          CTL_HOLD     = 2;
  localparam logic [2:0]  CTRL_RESET   = 3'h0;
  localparam int          STS_REL      = 0;
  localparam int          STS_REFP     = 1;
  localparam int          STS_BUSY     = 2;
  localparam int          STS_STATE    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // timing, in half bus cycles (one mclk each, bus clock = mclk / 2)
  localparam int          MCLK_MHZ     = 250;
  localparam int          BUS_DIV      = 2;
  localparam real         RECLAIM_CYC  = 1.5;
  localparam logic [5:0]  RECLAIM_HC   = 6'(int'(RECLAIM_CYC * BUS_DIV));
  localparam logic [5:0]  CPU_INT_HC   = 6'h04;
  localparam logic [5:0]  DMA_INT_HC   = 6'h04;
  localparam logic [5:0]  READ_IDLE_HC = 6'h02;
  localparam logic [5:0]  WDAT_HC      = 6'h02;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [10:0] {
    ST_IDLE    = 11'h001,
    ST_GAP     = 11'h002,
    ST_ACC     = 11'h004,
    ST_PRECHARGE_EVERY_BANK    = 11'h008,
    ST_REL_AD  = 11'h010,
    ST_REL_ACK = 11'h020,
    ST_REL_CTL = 11'h040,
    ST_RELD    = 11'h080,
    ST_RCL     = 11'h100,
    ST_RCL_ACK = 11'h200,
    ST_RESUME  = 11'h400
  } ebaidl_state_e;

  typedef enum logic [3:0] {
    MT_SRAM, MT_BROM_A, MT_MPXIO, MT_BSRAM0, MT_BSRAM1,
    MT_SDRAM, MT_SDRAM_LF, MT_PCMCIA, MT_BMPX, MT_BROM_S
  } ebaidl_mem_e;

  typedef struct packed {
    logic        write;
    logic        dma;
    logic        dual;
    logic [1:0]  chan;
    logic        divided;
    ebaidl_mem_e mem_type;
    logic [3:0]  reg_idle;
    logic [1:0]  wait_idle;
    logic [3:0]  len;
    logic [4:0]  no_release;
  } ebaidl_acc_s;

  // memory-type switch idle, half cycles; row = previous, nibble = next (MSB first)
  localparam logic [39:0] MEM_IDLE_HC [10] = '{
    40'h00_2022_3000, 40'h00_2022_3000, 40'h22_0222_3222,
    40'h00_2022_3000, 40'h22_2202_3222, 40'h33_3333_1533,
    40'h33_3333_3533, 40'h00_2022_3000, 40'h00_2022_3000,
    40'h00_2022_3000
  };

endpackage : ebaidl_pkg

// file: rtl/ebaidl_sync.sv
module ebaidl_sync #(
  parameter int         WIDTH     = 1,
  parameter logic [0:0] RESET_VAL = 1'b1
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= {WIDTH{RESET_VAL}};
      sync_out <= {WIDTH{RESET_VAL}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : ebaidl_sync

// file: rtl/ebaidl_idle_calc.sv
module ebaidl_idle_calc (
  // previous and next access
  input  wire logic                    prev_valid_in,
  input  wire ebaidl_pkg::ebaidl_acc_s prev_in,
  input  wire ebaidl_pkg::ebaidl_acc_s next_in,
  // gap in half bus cycles
  output logic [5:0]                   gap_hc_out
);

  logic [39:0] mem_row;
  logic [3:0]  mem_sel;
  logic [5:0]  c12, c34, c5, c6, c7, c567, c8, m1, m2, m3;
  logic        same_ch, cpu_wr, dual_same, sgl_same;

  assign c12       = {1'b0, prev_in.reg_idle, 1'b0};
  assign c34       = {3'b000, prev_in.wait_idle, 1'b0};
  assign c5        = (!prev_in.write && !prev_in.divided) ? ebaidl_pkg::READ_IDLE_HC : 6'h00;
  assign same_ch   = prev_in.chan == next_in.chan;
  assign cpu_wr    = !next_in.dma && next_in.write;
  assign dual_same = next_in.dma && next_in.dual && prev_in.write && !next_in.write
                     && same_ch;
  assign sgl_same  = next_in.dma && !next_in.dual && (prev_in.write == next_in.write);
  assign c6        = next_in.divided ? 6'h00 :
                     cpu_wr ? ebaidl_pkg::CPU_INT_HC :
                     (dual_same || sgl_same) ? ebaidl_pkg::DMA_INT_HC : 6'h00;
  assign c7        = (next_in.write && !prev_in.write) ? ebaidl_pkg::WDAT_HC : 6'h00;
  assign c567      = 6'(c5 + c6 + c7);
  assign mem_row   = ebaidl_pkg::MEM_IDLE_HC[prev_in.mem_type];
  assign mem_sel   = 4'(4'h9 - next_in.mem_type);
  assign c8        = {2'b00, mem_row[{mem_sel, 2'b00} +: 4]};
  assign m1        = (c12 > c34) ? c12 : c34;
  assign m2        = (c567 > c8) ? c567 : c8;
  assign m3        = (m1 > m2) ? m1 : m2;
  assign gap_hc_out = prev_valid_in ? m3 : 6'h00;

endmodule : ebaidl_idle_calc

// file: rtl/ebaidl_top.sv
// The plain strobed port and the address map were decided locally.
module ebaidl_top (
  // clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    resetn_in,
  // register port
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [31:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [31:0]             reg_rdata_out,
  // internal access requests
  input  wire logic                    acc_valid_in,
  input  wire ebaidl_pkg::ebaidl_acc_s acc_in,
  output logic                         acc_ready_out,
  output logic                         acc_active_out,
  output logic                         acc_done_out,
  // arbitration pins
  input  wire logic                    ext_master_request_n_in,
  output logic                         bus_ack_n_out,
  output logic                         bus_ack_oe_out,
  output logic                         bus_clock_out,
  output logic                         addr_data_oe_out,
  output logic                         ctl_oe_out,
  output logic                         sdram_hold_oe_out,
  output logic                         refresh_need_out_n,
  // sdram
  input  wire logic                    sdram_active_in,
  input  wire logic                    precharge_every_bank_done_in,
  output logic                         precharge_every_bank_out,
  // system
  input  wire logic                    standby_in,
  input  wire logic                    sleep_req_in,
  output logic                         sleep_grant_out,
  input  wire logic                    mreset_req_in,
  output logic                         mreset_go_out,
  input  wire logic                    refresh_due_in,
  input  wire logic                    dma_burst_in
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  ebaidl_pkg::ebaidl_state_e state_reg;
  ebaidl_pkg::ebaidl_state_e state_next;
  ebaidl_pkg::ebaidl_acc_s   cur_reg;
  ebaidl_pkg::ebaidl_acc_s   prev_reg;
  logic                      prev_vld_reg;
  logic [5:0]                cnt_reg;
  logic [5:0]                cnt_next;
  logic [5:0]                gap_hc;
  logic [5:0]                gap_last_reg;
  logic [2:0]                ctrl_reg;
  logic                      lock_reg;
  logic                      refp_reg;
  logic                      req_sync;
  logic                      ack_n_next;
  logic                      ad_oe_next;
  logic                      ctl_oe_next;
  logic                      precharge_every_bank_next;
  logic                      done_next;
  logic                      refp_next;
  logic [31:0]               rdata_next;
  logic [31:0]               status_word;
  logic                      rise;
  logic                      fall;
  logic                      req_low;
  logic                      burst_hold;
  logic                      grant_ok;
  logic                      acc_take;
  logic                      owned_idle;
  logic                      ready_next;
  logic                      ctrl_wr;
  logic [5:0]                acc_len_hc;

  ////////////////////////////////////////////////////////////////////////////
  // request synchroniser and idle gap

  ebaidl_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_req_sync (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .async_in  (ext_master_request_n_in),
    .sync_out  (req_sync)
  );

  ebaidl_idle_calc u_idle (
    .prev_valid_in (prev_vld_reg),
    .prev_in       (prev_reg),
    .next_in       (acc_in),
    .gap_hc_out    (gap_hc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // the edge about to come makes the bus clock rise when it is low now
  assign rise       = !bus_clock_out;
  assign fall       = bus_clock_out;
  assign req_low    = !req_sync && !standby_in;
  assign burst_hold = dma_burst_in && !ctrl_reg[ebaidl_pkg::CTL_DPR];
  assign grant_ok   = req_low && fall && !burst_hold && !lock_reg
                      && !ctrl_reg[ebaidl_pkg::CTL_BLOCK];
  assign acc_take   = acc_valid_in && acc_ready_out && (state_reg == ebaidl_pkg::ST_IDLE);
  assign owned_idle = (state_reg == ebaidl_pkg::ST_IDLE) && !acc_take;
  assign acc_len_hc = {1'b0, cur_reg.len, 1'b0};
  // manual reset request stops new cycles; the running one completes
  assign ready_next = (state_next == ebaidl_pkg::ST_IDLE) && !mreset_req_in;
  assign refp_next  = refresh_due_in || (refp_reg && (state_reg != ebaidl_pkg::ST_IDLE));
  assign ctrl_wr    = reg_wr_in && (reg_addr_in == ebaidl_pkg::OFS_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // arbitration and access sequencer

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    ack_n_next  = bus_ack_n_out;
    ad_oe_next  = addr_data_oe_out;
    ctl_oe_next = ctl_oe_out;
    precharge_every_bank_next   = 1'b0;
    done_next   = 1'b0;
    case (state_reg)
      ebaidl_pkg::ST_IDLE: begin
        ad_oe_next  = 1'b1;
        ctl_oe_next = 1'b1;
        if (acc_take) begin
          state_next = ebaidl_pkg::ST_GAP;
          cnt_next   = gap_hc;
        end else if (grant_ok) begin
          if (sdram_active_in) begin
            state_next = ebaidl_pkg::ST_PRECHARGE_EVERY_BANK;
            precharge_every_bank_next  = 1'b1;
          end else begin
            state_next = ebaidl_pkg::ST_REL_AD;
          end
        end
      end
      ebaidl_pkg::ST_GAP: begin
        if (cnt_reg != 6'h00) begin
          cnt_next = 6'(cnt_reg - 6'h01);
        end else if (rise) begin
          state_next = ebaidl_pkg::ST_ACC;
          cnt_next   = 6'(acc_len_hc - 6'h01);
        end
      end
      ebaidl_pkg::ST_ACC: begin
        if (cnt_reg != 6'h00) begin
          cnt_next = 6'(cnt_reg - 6'h01);
        end else begin
          state_next = ebaidl_pkg::ST_IDLE;
          done_next  = 1'b1;
        end
      end
      ebaidl_pkg::ST_PRECHARGE_EVERY_BANK: begin
        if (precharge_every_bank_done_in) begin
          state_next = ebaidl_pkg::ST_REL_AD;
        end
      end
      ebaidl_pkg::ST_REL_AD: begin
        if (rise) begin
          state_next = ebaidl_pkg::ST_REL_ACK;
          ad_oe_next = 1'b0;
        end
      end
      ebaidl_pkg::ST_REL_ACK: begin
        if (fall) begin
          state_next = ebaidl_pkg::ST_REL_CTL;
          ack_n_next = 1'b0;
        end
      end
      ebaidl_pkg::ST_REL_CTL: begin
        if (rise) begin
          state_next  = ebaidl_pkg::ST_RELD;
          ctl_oe_next = 1'b0;
        end
      end
      ebaidl_pkg::ST_RELD: begin
        if (fall && !req_sync == 1'b0 && !standby_in) begin
          state_next = ebaidl_pkg::ST_RCL;
          cnt_next   = 6'(ebaidl_pkg::RECLAIM_HC - 6'h01);
        end
      end
      ebaidl_pkg::ST_RCL: begin
        if (cnt_reg != 6'h00) begin
          cnt_next = 6'(cnt_reg - 6'h01);
        end else begin
          state_next  = ebaidl_pkg::ST_RCL_ACK;
          ctl_oe_next = 1'b1;
        end
      end
      ebaidl_pkg::ST_RCL_ACK: begin
        if (fall) begin
          state_next = ebaidl_pkg::ST_RESUME;
          ack_n_next = 1'b1;
        end
      end
      ebaidl_pkg::ST_RESUME: begin
        if (rise) begin
          state_next = ebaidl_pkg::ST_IDLE;
          ad_oe_next = 1'b1;
        end
      end
      default: begin
        state_next = ebaidl_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ebaidl_pkg::ST_IDLE;
      cnt_reg   <= 6'h00;
      bus_clock_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bus_clock_out <= !bus_clock_out;
    end
  end

  // pins: reset leaves strobes negated and address/data buffers off
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_ack_n_out            <= 1'b1;
      addr_data_oe_out         <= 1'b0;
      ctl_oe_out               <= 1'b1;
      sdram_hold_oe_out        <= 1'b1;
      bus_ack_oe_out           <= 1'b1;
      precharge_every_bank_out <= 1'b0;
    end else begin
      bus_ack_n_out            <= ack_n_next;
      addr_data_oe_out         <= ad_oe_next;
      ctl_oe_out               <= ctl_oe_next;
      sdram_hold_oe_out        <= ctl_oe_next || ctrl_reg[ebaidl_pkg::CTL_HOLD];
      bus_ack_oe_out           <= !standby_in;
      precharge_every_bank_out <= precharge_every_bank_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access bookkeeping

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur_reg      <= '0;
      prev_reg     <= '0;
      prev_vld_reg <= 1'b0;
      lock_reg     <= 1'b0;
      gap_last_reg <= 6'h00;
    end else begin
      if (acc_take) begin
        cur_reg      <= acc_in;
        gap_last_reg <= gap_hc;
        lock_reg     <= acc_in.no_release != 5'h00;
      end
      if (done_next) begin
        prev_reg     <= cur_reg;
        prev_vld_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_ready_out  <= 1'b0;
      acc_active_out <= 1'b0;
      acc_done_out   <= 1'b0;
    end else begin
      acc_ready_out  <= ready_next;
      acc_active_out <= state_next == ebaidl_pkg::ST_ACC;
      acc_done_out   <= done_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refresh, sleep and manual reset

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      refp_reg           <= 1'b0;
      refresh_need_out_n <= 1'b1;
      sleep_grant_out    <= 1'b0;
      mreset_go_out      <= 1'b0;
    end else begin
      refp_reg           <= refp_next;
      refresh_need_out_n <= !(refp_next && !ack_n_next);
      sleep_grant_out    <= sleep_req_in && owned_idle;
      mreset_go_out      <= mreset_req_in && owned_idle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port

  assign status_word = {17'h0_0000, state_reg, 1'b0, (state_reg != ebaidl_pkg::ST_IDLE),
                        refp_reg, !bus_ack_n_out};
  assign rdata_next  = !reg_rd_in ? 32'h0000_0000 :
                       (reg_addr_in == ebaidl_pkg::OFS_CTRL)   ? {29'h0, ctrl_reg} :
                       (reg_addr_in == ebaidl_pkg::OFS_STATUS) ? status_word :
                       (reg_addr_in == ebaidl_pkg::OFS_GAP)    ? {26'h0, gap_last_reg} :
                       32'h0000_0000;

  // only power-on reset clears control; manual reset leaves it alone
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg      <= ebaidl_pkg::CTRL_RESET;
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= reg_wdata_in[2:0];
      end
      reg_rdata_out <= rdata_next;
    end
  end

endmodule : ebaidl_top

// file: testbench/ebaidl_sva.sv
module ebaidl_sva (
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // watched inputs
  input wire logic ext_master_request_n_in,
  input wire logic standby_in,
  input wire logic mreset_req_in,
  // watched outputs
  input wire logic acc_ready_out,
  input wire logic acc_active_out,
  input wire logic bus_ack_n_out,
  input wire logic bus_ack_oe_out,
  input wire logic addr_data_oe_out,
  input wire logic ctl_oe_out,
  input wire logic refresh_need_out_n,
  input wire logic sleep_grant_out,
  input wire logic mreset_go_out,
  input wire logic precharge_every_bank_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  a_float_then_ack: assert property (
    $fell(addr_data_oe_out) |=> !bus_ack_n_out) else $error("ack late after float");
  a_ack_then_ctl: assert property (
    $fell(bus_ack_n_out) |=> !ctl_oe_out) else $error("strobes late");
  a_reclaim_order: assert property (
    $rose(ctl_oe_out) |=> $rose(bus_ack_n_out) ##1 $rose(addr_data_oe_out))
    else $error("reclaim order broken");
  a_req_synced: assert property (
    $fell(addr_data_oe_out) |-> !$past(ext_master_request_n_in, 3))
    else $error("release before sync");
  a_ack_held_low: assert property (
    (!bus_ack_n_out && !ext_master_request_n_in) [*6] |=> !bus_ack_n_out)
    else $error("ack dropped");
  a_busy_owned: assert property (
    acc_active_out |-> addr_data_oe_out && bus_ack_n_out) else $error("released mid cycle");
  a_refresh_rel: assert property (
    !refresh_need_out_n |-> !bus_ack_n_out || !$past(bus_ack_n_out))
    else $error("refresh request while owned");
  a_standby_float: assert property (
    standby_in |=> !bus_ack_oe_out) else $error("ack driven in standby");
  a_grant_owned: assert property (
    sleep_grant_out || mreset_go_out |-> bus_ack_n_out && ctl_oe_out)
    else $error("sleep or reset while released");
  a_mreset_stop: assert property (
    mreset_req_in |=> !acc_ready_out) else $error("ready in reset");
  a_precharge_every_bank_owned: assert property (
    precharge_every_bank_out |-> addr_data_oe_out && bus_ack_n_out)
    else $error("precharge after release");
endmodule : ebaidl_sva

// file: testbench/ebaidl_ext_master.sv
module ebaidl_ext_master (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  // bench control and device pins
  input  wire logic want_bus_in,
  input  wire logic bus_ack_n_in,
  input  wire logic refresh_need_n_in,
  output logic      request_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic spent_reg;

  // once given back, no new request until want_bus_in drops
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      request_n_out <= 1'b1;
      spent_reg     <= 1'b0;
    end else if (request_n_out) begin
      request_n_out <= !(want_bus_in && !spent_reg);
      spent_reg     <= spent_reg && want_bus_in;
    end else if (!bus_ack_n_in && (!want_bus_in || !refresh_need_n_in)) begin
      request_n_out <= 1'b1;
      spent_reg     <= 1'b1;
    end
  end
endmodule : ebaidl_ext_master

// file: testbench/tb.sv
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
`define WAITC(c) for (int w = 0; w < 80; w++) begin @(posedge mclk_in); #1; if (c) break; end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam ebaidl_pkg::ebaidl_mem_e SR = ebaidl_pkg::MT_SRAM;
  logic mclk_in, resetn_in, reg_wr_in, reg_rd_in, acc_valid_in, want_bus;
  logic [7:0]              reg_addr_in;
  logic [31:0]             reg_wdata_in, reg_rdata_out;
  ebaidl_pkg::ebaidl_acc_s acc_in;
  logic acc_ready_out, acc_active_out, acc_done_out, ext_master_request_n_in, bus_ack_n_out;
  logic bus_ack_oe_out, bus_clock_out, addr_data_oe_out, ctl_oe_out, sdram_hold_oe_out;
  logic refresh_need_out_n, sdram_active_in, precharge_every_bank_done_in, precharge_every_bank_out;
  logic standby_in, sleep_req_in, sleep_grant_out, mreset_req_in, mreset_go_out;
  logic refresh_due_in, dma_burst_in;
  int   n_fail, samples_checked;

  ebaidl_top u_dut (.mclk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .acc_valid_in, .acc_in, .acc_ready_out, .acc_active_out, .acc_done_out,
    .ext_master_request_n_in, .bus_ack_n_out, .bus_ack_oe_out, .bus_clock_out,
    .addr_data_oe_out, .ctl_oe_out, .sdram_hold_oe_out, .refresh_need_out_n,
    .sdram_active_in, .precharge_every_bank_done_in, .precharge_every_bank_out, .standby_in, .sleep_req_in,
    .sleep_grant_out, .mreset_req_in, .mreset_go_out, .refresh_due_in, .dma_burst_in);

  ebaidl_ext_master u_master (.mclk_in(mclk_in), .resetn_in(resetn_in), .want_bus_in(want_bus),
    .bus_ack_n_in(bus_ack_n_out), .refresh_need_n_in(refresh_need_out_n),
    .request_n_out(ext_master_request_n_in));

  always #2 mclk_in = ~mclk_in;

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in   <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : reg_rd

  task automatic request(input bit exp);
    @(posedge mclk_in);
    want_bus <= 1'b1;
    `WAITC(bus_ack_n_out === 1'b0)
    `CHK("bus granted", exp, !bus_ack_n_out)
  endtask : request

  task automatic reclaim();
    @(posedge mclk_in);
    want_bus <= 1'b0;
    `WAITC(bus_ack_n_out === 1'b1)
    `CHK("strobes at ack rise", 1, ctl_oe_out)
    `CHK("address off at ack rise", 0, addr_data_oe_out)
    @(posedge mclk_in);
    #1;
    `CHK("address back", 1, addr_data_oe_out)
  endtask : reclaim

  task automatic do_acc(input bit wr, dma, dual, input logic [1:0] ch,
                        input ebaidl_pkg::ebaidl_mem_e mt, input logic [3:0] ri, input int exp);
    int          n;
    bit          kept;
    logic [31:0] d;
    n = 0;
    kept = 1'b1;
    `WAITC(acc_ready_out === 1'b1)
    @(posedge mclk_in);
    acc_in <= '{write: wr, dma: dma, dual: dual, chan: ch, divided: 1'b0, mem_type: mt,
                reg_idle: ri, wait_idle: 2'h0, len: 4'h3, no_release: 5'h00};
    acc_valid_in <= 1'b1;
    @(posedge mclk_in);
    acc_valid_in <= 1'b0;
    for (int w = 0; w < 200 && acc_done_out !== 1'b1; w++) begin
      @(posedge mclk_in);
      #1;
      n += int'(acc_active_out === 1'b1);
      if (acc_active_out === 1'b1 && bus_ack_n_out !== 1'b1) kept = 1'b0;
    end
    `CHK("active length", 6, n)
    `CHK("owned while active", 1, kept)
    reg_rd(ebaidl_pkg::OFS_GAP, d);
    if (exp >= 0) `CHK("idle gap", exp, d[5:0])
  endtask : do_acc

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(ebaidl_pkg::OFS_CTRL, d);
    `CHK("ctrl reset", 0, d)
    reg_rd(ebaidl_pkg::OFS_STATUS, d);
    `CHK("status reset", 32'(ebaidl_pkg::ST_IDLE) << ebaidl_pkg::STS_STATE, d)
    `CHK("ack idle", 1, bus_ack_n_out)
    reg_wr(ebaidl_pkg::OFS_CTRL, 32'h0000_0007);
    reg_wr(8'h0c, 32'hffff_ffff);
    reg_rd(ebaidl_pkg::OFS_CTRL, d);
    `CHK("ctrl kept", 32'h0000_0007, d)
    reg_rd(8'h0c, d);
    `CHK("unmapped", 0, d)
    reg_wr(ebaidl_pkg::OFS_CTRL, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_gaps();
    do_acc(0, 0, 0, 2'h0, SR, 4'h0, 0);
    do_acc(0, 0, 0, 2'h0, SR, 4'h0, 2);
    do_acc(0, 0, 0, 2'h0, ebaidl_pkg::MT_SDRAM_LF, 4'h0, 3);
    do_acc(1, 0, 0, 2'h0, SR, 4'h0, 8);
    do_acc(1, 0, 0, 2'h0, SR, 4'h0, 4);
    do_acc(0, 0, 0, 2'h0, SR, 4'h0, 0);
    do_acc(1, 0, 0, 2'h0, SR, 4'h6, 8);
    do_acc(1, 1, 1, 2'h0, SR, 4'h0, 12);
    do_acc(0, 1, 1, 2'h0, SR, 4'h0, 4);
    do_acc(1, 1, 1, 2'h1, SR, 4'h0, -1);
    do_acc(0, 1, 1, 2'h2, SR, 4'h0, 0);
    do_acc(1, 1, 0, 2'h1, SR, 4'h0, -1);
    do_acc(0, 1, 0, 2'h2, SR, 4'h0, 0);
    $display("test gaps done");
  endtask : t_gaps

  task automatic t_release();
    logic [31:0] d;
    for (int h = 0; h < 2; h++) begin
      reg_wr(ebaidl_pkg::OFS_CTRL, 32'(h) << ebaidl_pkg::CTL_HOLD);
      request(1'b1);
      `CHK("address floated", 0, addr_data_oe_out)
      `CHK("clock low at ack", 0, bus_clock_out)
      @(posedge mclk_in);
      #1;
      `CHK("strobes floated", 0, ctl_oe_out)
      `CHK("sdram hold", h, sdram_hold_oe_out)
      reg_rd(ebaidl_pkg::OFS_STATUS, d);
      `CHK("released flag", 1, d[ebaidl_pkg::STS_REL])
      reclaim();
    end
    $display("test release done");
  endtask : t_release

  task automatic t_refuse();
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_in);
      dma_burst_in <= (i == 1);
      standby_in   <= (i == 2);
      reg_wr(ebaidl_pkg::OFS_CTRL, 32'(i == 0));
      request(1'b0);
      `CHK("ack driven", i != 2, bus_ack_oe_out)
      @(posedge mclk_in);
      standby_in <= 1'b0;
      reg_wr(ebaidl_pkg::OFS_CTRL, 32'(i == 1) << ebaidl_pkg::CTL_DPR);
      request(1'b1);
      reclaim();
    end
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_sdram();
    @(posedge mclk_in);
    sdram_active_in <= 1'b1;
    want_bus        <= 1'b1;
    `WAITC(precharge_every_bank_out === 1'b1)
    `CHK("precharge issued", 1, precharge_every_bank_out)
    repeat (8) @(posedge mclk_in);
    #1;
    `CHK("held for precharge", 1, bus_ack_n_out)
    @(posedge mclk_in);
    precharge_every_bank_done_in    <= 1'b1;
    sdram_active_in <= 1'b0;
    request(1'b1);
    @(posedge mclk_in);
    precharge_every_bank_done_in <= 1'b0;
    reclaim();
    $display("test sdram done");
  endtask : t_sdram

  task automatic t_power();
    request(1'b1);
    @(posedge mclk_in);
    sleep_req_in  <= 1'b1;
    mreset_req_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    #1;
    `CHK("sleep deferred", 0, sleep_grant_out)
    `CHK("reset deferred", 0, mreset_go_out)
    `CHK("no access in reset", 0, acc_ready_out)
    reclaim();
    `WAITC(sleep_grant_out === 1'b1)
    `CHK("sleep granted", 1, sleep_grant_out)
    `CHK("reset granted", 1, mreset_go_out)
    @(posedge mclk_in);
    sleep_req_in  <= 1'b0;
    mreset_req_in <= 1'b0;
    $display("test power done");
  endtask : t_power

  task automatic t_refresh();
    request(1'b1);
    @(posedge mclk_in);
    refresh_due_in <= 1'b1;
    @(posedge mclk_in);
    refresh_due_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
    `CHK("refresh asked", 0, refresh_need_out_n)
    `WAITC(bus_ack_n_out === 1'b1)
    `CHK("bus returned", 1, bus_ack_n_out)
    repeat (4) @(posedge mclk_in);
    #1;
    `CHK("refresh ask ends", 1, refresh_need_out_n)
    @(posedge mclk_in);
    want_bus <= 1'b0;
    $display("test refresh done");
  endtask : t_refresh

  task automatic t_busy();
    fork
      do_acc(1, 0, 0, 2'h0, SR, 4'hf, 8);
      begin
        repeat (4) @(posedge mclk_in);
        want_bus <= 1'b1;
      end
    join
    request(1'b1);
    reclaim();
    $display("test busy done");
  endtask : t_busy

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    report_and_stop();
  end

  initial begin
    {mclk_in, resetn_in, reg_wr_in, reg_rd_in, acc_valid_in, want_bus} = '0;
    {reg_addr_in, reg_wdata_in, acc_in, sdram_active_in, precharge_every_bank_done_in} = '0;
    {standby_in, sleep_req_in, mreset_req_in, refresh_due_in, dma_burst_in} = '0;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge mclk_in);
    resetn_in <= 1'b1;
    t_regs();
    t_gaps();
    t_release();
    t_refuse();
    t_sdram();
    t_power();
    t_refresh();
    t_busy();
    report_and_stop();
  end
endmodule : tb

bind ebaidl_top ebaidl_sva u_sva (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .ext_master_request_n_in(ext_master_request_n_in), .standby_in(standby_in),
  .mreset_req_in(mreset_req_in), .acc_ready_out(acc_ready_out),
  .acc_active_out(acc_active_out), .bus_ack_n_out(bus_ack_n_out),
  .bus_ack_oe_out(bus_ack_oe_out), .addr_data_oe_out(addr_data_oe_out),
  .ctl_oe_out(ctl_oe_out), .refresh_need_out_n(refresh_need_out_n),
  .sleep_grant_out(sleep_grant_out), .mreset_go_out(mreset_go_out),
  .precharge_every_bank_out(precharge_every_bank_out));
